// >>> rtcirq_pkg.sv
// rtcirq_pkg: register map, field positions, carriers and timing constants
// for the real-time clock flag and interrupt-output block.
// assumes a 40 MHz system clock and tick strobes made on that same clock.

package rtcirq_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h00;
  localparam logic [7:0] ADDR_FLAG_EN      = 8'h01;
  localparam logic [7:0] ADDR_TIMER_CTRL   = 8'h0e;
  localparam logic [7:0] ADDR_CD_VALUE     = 8'h0f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_CORR_SHORTEN = 1;  // in the primary control register
  localparam int BIT_RUN          = 3;  // timer control: countdown_run
  localparam int BIT_SEL_HI       = 1;  // timer control: clock select hi
  localparam int BIT_SEL_LO       = 0;  // timer control: clock select lo

  // reset values
  localparam logic [7:0] FLAG_EN_RST    = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h03;  // slowest source, stopped
  localparam logic [7:0] CD_VALUE_RST   = 8'h00;

  // countdown source clock selections
  localparam logic [1:0] SEL_4096HZ = 2'h0;
  localparam logic [1:0] SEL_64HZ   = 2'h1;
  localparam logic [1:0] SEL_1HZ    = 2'h2;
  localparam logic [1:0] SEL_60S    = 2'h3;

  // ---------------------------------------------------------------
  // timing: pulse lengths as fractions of a second, converted to cycles
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int DIV_MS_PULSE  = 64;    // minute/second pulse, 1/64 s
  localparam int DIV_CORR      = 128;   // correction pulse, 1/128 s
  localparam int DIV_CD_FAST   = 4096;  // countdown, 4.096 kHz, n > 1
  localparam int DIV_CD_FAST1  = 8192;  // countdown, 4.096 kHz, n = 1
  localparam int DIV_CD_SLOW   = 64;    // countdown, other clocks
  localparam int DIV_CD_SLOW1  = 128;   // countdown, 64 Hz, n = 1
  localparam int CYC_MS_PULSE  = CLK_HZ / DIV_MS_PULSE;
  localparam int CYC_CORR      = CLK_HZ / DIV_CORR;
  localparam int CYC_CD_FAST   = CLK_HZ / DIV_CD_FAST;
  localparam int CYC_CD_FAST1  = CLK_HZ / DIV_CD_FAST1;
  localparam int CYC_CD_SLOW   = CLK_HZ / DIV_CD_SLOW;
  localparam int CYC_CD_SLOW1  = CLK_HZ / DIV_CD_SLOW1;

  // flag-and-enable register layout, bit 7 down to bit 0
  typedef struct packed {
    logic per_60s_irq_en;
    logic per_1s_irq_en;
    logic minute_second_flag;
    logic timer_pulse_select;
    logic alarm_flag;
    logic countdown_flag;
    logic alarm_irq_en;
    logic countdown_irq_en;
  } rtcirq_flag_en_s;

  // register access strobe from the serial front end
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcirq_reg_req_s;

endpackage : rtcirq_pkg

// >>> rtcirq_top.sv
// rtcirq_top: sticky flags, write-and clear, countdown counter, pulse
// generators and the open-drain active-low interrupt pin of the clock.
// assumes the serial front end and tick strobes run on sys_clk.

`timescale 1ns/10ps

module rtcirq_top #(
  parameter int MS_PULSE_CYC  = rtcirq_pkg::CYC_MS_PULSE,
  parameter int CORR_CYC      = rtcirq_pkg::CYC_CORR,
  parameter int CD_FAST_CYC   = rtcirq_pkg::CYC_CD_FAST,
  parameter int CD_FAST1_CYC  = rtcirq_pkg::CYC_CD_FAST1,
  parameter int CD_SLOW_CYC   = rtcirq_pkg::CYC_CD_SLOW,
  parameter int CD_SLOW1_CYC  = rtcirq_pkg::CYC_CD_SLOW1,
  parameter int CNT_W         = 20
) (
  // clock, reset, enable
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  // register access from the serial front end
  input  wire rtcirq_pkg::rtcirq_reg_req_s reg_req,
  output logic [7:0]                       reg_rdata,
  // event and tick strobes, one cycle each
  input  wire logic                        sec_tick,
  input  wire logic                        min_tick,
  input  wire logic                        alarm_event,
  input  wire logic                        corr_event,
  input  wire logic                        tick_4096hz,
  input  wire logic                        tick_64hz,
  input  wire logic                        tick_1hz,
  input  wire logic                        tick_60s,
  // open-drain interrupt pin
  output logic                             int_pin_out,
  output logic                             int_pin_oe_n
);

  // ---------------------------------------------------------------
  // register state and decode
  // ---------------------------------------------------------------
  rtcirq_pkg::rtcirq_flag_en_s flag_en;
  rtcirq_pkg::rtcirq_flag_en_s wr_val;
  logic [7:0]                  timer_ctrl;
  logic [7:0]                  cd_value;
  logic [7:0]                  cd_count;

  // one-hot decode of a write at a given offset
  function automatic logic wr_at(input rtcirq_pkg::rtcirq_reg_req_s r,
                                 input logic [7:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction : wr_at

  logic wr_flag_en;
  logic wr_timer;
  logic wr_cd;
  logic wr_shorten;
  logic ms_set;
  logic cd_set;
  logic al_set;
  logic cd_step;
  logic [1:0] cd_sel;

  // write strobes and event conditions
  assign wr_flag_en = ce && wr_at(reg_req, rtcirq_pkg::ADDR_FLAG_EN);
  assign wr_timer   = ce && wr_at(reg_req, rtcirq_pkg::ADDR_TIMER_CTRL);
  assign wr_cd      = ce && wr_at(reg_req, rtcirq_pkg::ADDR_CD_VALUE);
  assign wr_shorten = ce && wr_at(reg_req, rtcirq_pkg::ADDR_CTRL_PRIMARY)
                      && reg_req.wdata[rtcirq_pkg::BIT_CORR_SHORTEN];
  assign wr_val     = reg_req.wdata;
  assign cd_sel     = {timer_ctrl[rtcirq_pkg::BIT_SEL_HI],
                       timer_ctrl[rtcirq_pkg::BIT_SEL_LO]};
  assign ms_set     = ce && ((sec_tick && flag_en.per_1s_irq_en) ||
                             (min_tick && flag_en.per_60s_irq_en));
  assign al_set     = ce && alarm_event;

  // ---------------------------------------------------------------
  // countdown counter
  // ---------------------------------------------------------------
  // selected source tick for the counter
  always_comb begin
    unique case (cd_sel)
      rtcirq_pkg::SEL_4096HZ: cd_step = tick_4096hz;
      rtcirq_pkg::SEL_64HZ:   cd_step = tick_64hz;
      rtcirq_pkg::SEL_1HZ:    cd_step = tick_1hz;
      rtcirq_pkg::SEL_60S:    cd_step = tick_60s;
    endcase
  end

  // counter reaching 1 marks the end of a period; zero holds it stopped
  assign cd_set = ce && timer_ctrl[rtcirq_pkg::BIT_RUN] && cd_step
                  && (cd_value != 8'h00) && (cd_count <= 8'h01);

  // down counter, reloaded at expiry and on a new value
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cd_count <= rtcirq_pkg::CD_VALUE_RST;
    end else if (wr_cd) begin
      cd_count <= reg_req.wdata;
    end else if (cd_set) begin
      cd_count <= cd_value;
    end else if (ce && timer_ctrl[rtcirq_pkg::BIT_RUN] && cd_step &&
                 cd_value != 8'h00) begin
      cd_count <= cd_count - 8'h01;
    end
  end

  // timer control and countdown value registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timer_ctrl <= rtcirq_pkg::TIMER_CTRL_RST;
      cd_value   <= rtcirq_pkg::CD_VALUE_RST;
    end else begin
      if (wr_timer) begin
        timer_ctrl <= reg_req.wdata;
      end
      if (wr_cd) begin
        cd_value <= reg_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // flag-and-enable register
  // ---------------------------------------------------------------
  // config bits take the written value; flags and with it, set wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flag_en <= rtcirq_pkg::FLAG_EN_RST;
    end else if (ce) begin
      if (wr_flag_en) begin
        flag_en.per_60s_irq_en     <= wr_val.per_60s_irq_en;
        flag_en.per_1s_irq_en      <= wr_val.per_1s_irq_en;
        flag_en.timer_pulse_select <= wr_val.timer_pulse_select;
        flag_en.alarm_irq_en       <= wr_val.alarm_irq_en;
        flag_en.countdown_irq_en   <= wr_val.countdown_irq_en;
      end
      flag_en.minute_second_flag <= ms_set || (flag_en.minute_second_flag &&
        !(wr_flag_en && !wr_val.minute_second_flag));
      flag_en.countdown_flag <= cd_set || (flag_en.countdown_flag &&
        !(wr_flag_en && !wr_val.countdown_flag));
      flag_en.alarm_flag <= al_set || (flag_en.alarm_flag &&
        !(wr_flag_en && !wr_val.alarm_flag));
    end
  end

  // ---------------------------------------------------------------
  // pulse generators
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] ms_pcnt;
  logic [CNT_W-1:0] cd_pcnt;
  logic [CNT_W-1:0] corr_pcnt;
  logic [CNT_W-1:0] cd_width;
  logic             ms_clr;
  logic             cd_clr;

  // a write that clears a flag without a same-cycle set
  assign ms_clr = wr_flag_en && !wr_val.minute_second_flag && !ms_set;
  assign cd_clr = wr_flag_en && !wr_val.countdown_flag && !cd_set;

  // countdown pulse width from source clock and reload value
  always_comb begin
    cd_width = CNT_W'(CD_SLOW_CYC);
    if (cd_sel == rtcirq_pkg::SEL_4096HZ) begin
      cd_width = (cd_value == 8'h01) ? CNT_W'(CD_FAST1_CYC)
                                     : CNT_W'(CD_FAST_CYC);
    end else if (cd_sel == rtcirq_pkg::SEL_64HZ &&
                 cd_value == 8'h01) begin
      cd_width = CNT_W'(CD_SLOW1_CYC);
    end
  end

  // minute/second pulse, one 64 Hz period, cut short by flag clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ms_pcnt <= '0;
    end else if (ce) begin
      if (ms_set) begin
        ms_pcnt <= CNT_W'(MS_PULSE_CYC);
      end else if (ms_clr) begin
        ms_pcnt <= '0;
      end else if (ms_pcnt != '0) begin
        ms_pcnt <= ms_pcnt - CNT_W'(1);
      end
    end
  end

  // countdown pulse, cut short by flag clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cd_pcnt <= '0;
    end else if (ce) begin
      if (cd_set) begin
        cd_pcnt <= cd_width;
      end else if (cd_clr) begin
        cd_pcnt <= '0;
      end else if (cd_pcnt != '0) begin
        cd_pcnt <= cd_pcnt - CNT_W'(1);
      end
    end
  end

  // correction pulse, 1/128 s, ended by a shorten write
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      corr_pcnt <= '0;
    end else if (ce) begin
      if (corr_event) begin
        corr_pcnt <= CNT_W'(CORR_CYC);
      end else if (wr_shorten) begin
        corr_pcnt <= '0;
      end else if (corr_pcnt != '0) begin
        corr_pcnt <= corr_pcnt - CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt combining
  // ---------------------------------------------------------------
  logic ms_req;
  logic cd_req;
  logic al_req;
  logic corr_req;
  logic irq_any;

  // countdown gated by enable and mode, alarm by enable, ms flag by its tick enables in level mode only, correction pulse ungated, then or-ed
  assign ms_req   = flag_en.timer_pulse_select ? (ms_pcnt != '0)
                  : (flag_en.minute_second_flag &&
                     (flag_en.per_60s_irq_en || flag_en.per_1s_irq_en));
  assign cd_req   = flag_en.countdown_irq_en &&
                    (flag_en.timer_pulse_select ? (cd_pcnt != '0)
                                                : flag_en.countdown_flag);
  assign al_req   = flag_en.alarm_irq_en && flag_en.alarm_flag;
  assign corr_req = (corr_pcnt != '0);
  assign irq_any  = ms_req || cd_req || al_req || corr_req;

  // open-drain pin: drives low only while a request is active
  assign int_pin_out  = 1'b0;
  assign int_pin_oe_n = !irq_any;

  // registered read data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      unique case (reg_req.addr)
        rtcirq_pkg::ADDR_FLAG_EN:    reg_rdata <= flag_en;
        rtcirq_pkg::ADDR_TIMER_CTRL: reg_rdata <= timer_ctrl;
        rtcirq_pkg::ADDR_CD_VALUE:   reg_rdata <= cd_count;
        default:                     reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_flag_write_clear_ms;
    wr_flag_en && !wr_val.minute_second_flag && !ms_set;
  endsequence

  sequence s_ms_released;
    !flag_en.minute_second_flag && ms_pcnt == '0;
  endsequence

  chk_ms_flag_set: assert property (ms_set |=>
    flag_en.minute_second_flag)
    else $error("minute/second flag not set by tick");

  chk_flag_hold: assert property (ce && !wr_flag_en &&
    flag_en.alarm_flag |=> flag_en.alarm_flag)
    else $error("alarm flag dropped without a write");

  chk_and_clear: assert property (wr_flag_en && !cd_set &&
    !wr_val.countdown_flag |=> !flag_en.countdown_flag)
    else $error("countdown flag not cleared by write");

  chk_rewrite_same: assert property (wr_flag_en &&
    wr_val == (flag_en | 8'h2c) |=> $stable(flag_en.per_60s_irq_en) &&
    $stable(flag_en.timer_pulse_select) && $stable(flag_en.alarm_irq_en))
    else $error("rewrite changed configuration");

  chk_ms_pulse_cut: assert property (s_flag_write_clear_ms
    |=> s_ms_released)
    else $error("minute/second pulse not cut by clear");

  chk_ms_pulse_len: assert property (ce && ms_set &&
    flag_en.timer_pulse_select |=> ms_pcnt == CNT_W'(MS_PULSE_CYC))
    else $error("minute/second pulse length wrong");

  chk_alarm_level: assert property (al_req |->
    !int_pin_oe_n)
    else $error("alarm request not driving the pin");

  chk_cd_gate: assert property (!flag_en.countdown_irq_en
    && !ms_req && !al_req && !corr_req |-> int_pin_oe_n)
    else $error("pin driven with countdown disabled");

  chk_cd_stopped: assert property (cd_value == 8'h00 |->
    !cd_set)
    else $error("countdown expired with zero reload");

  chk_set_wins: assert property (al_set && wr_flag_en
    |=> flag_en.alarm_flag)
    else $error("alarm event lost to a clear");

  chk_corr_shorten: assert property (ce && wr_shorten &&
    !corr_event |=> corr_pcnt == '0)
    else $error("correction pulse not shortened");

  chk_cd_reload: assert property (cd_set && !wr_cd |=>
    flag_en.countdown_flag && cd_count == $past(cd_value))
    else $error("countdown did not reload at expiry");

endmodule : rtcirq_top

// >>> rtcirq_host_model.sv
// rtcirq_host_model: host side of the open-drain interrupt pin.
// assumes a pull-up on the wire and that only the device pulls it low.

`timescale 1ns/10ps

module rtcirq_host_model (
  // pin as driven by the device
  input  wire logic int_pin_out,
  input  wire logic int_pin_oe_n,
  // level the host interrupt input sees
  output logic      irq_n
);

  // ---------------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------------
  // released pin floats up through the pull-up
  assign irq_n = int_pin_oe_n ? 1'b1 : int_pin_out;

endmodule : rtcirq_host_model

// >>> rtcirq_top_tb.sv
// rtcirq_top_tb: self-checking bench for the flag and interrupt block.
// assumes short pulse counts set by parameter and ce held high except in the freeze check.

`timescale 1ns/10ps

`define CHK(what, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end

module rtcirq_top_tb;

  // ---------------------------------------------------------------
  // settings and stimulus signals
  // ---------------------------------------------------------------
  localparam int P_MS = 16;
  localparam int P_CORR = 8;
  localparam int P_F = 4;
  localparam int P_F1 = 2;
  localparam int P_S = 16;
  localparam int P_S1 = 8;

  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] ev;
    logic [7:0] flags;
    logic       pin;
  } rtcirq_row_s;

  logic                        sys_clk = 1'b0;
  logic                        nrst = 1'b0;
  logic                        ce = 1'b1;
  rtcirq_pkg::rtcirq_reg_req_s req = '0;
  logic [7:0]                  reg_rdata;
  logic [3:0]                  ev = 4'h0;  // sec, min, alarm, corr
  logic [3:0]                  tk = 4'h0;  // 4096, 64, 1, 1/60 strobes
  logic                        pin_out;
  logic                        pin_oe_n;
  logic                        irq_n;
  logic [7:0]                  d;
  int                          fails = 0;
  int                          comparisons = 0;
  int                          cycles = 0;
  int                          w;
  int                          w_exp;
  rtcirq_row_s                 rows [7];

  always #12.5 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // design and host
  // ---------------------------------------------------------------
  rtcirq_top #(.MS_PULSE_CYC(P_MS), .CORR_CYC(P_CORR), .CD_FAST_CYC(P_F),
    .CD_FAST1_CYC(P_F1), .CD_SLOW_CYC(P_S), .CD_SLOW1_CYC(P_S1)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .reg_req(req),
    .reg_rdata(reg_rdata), .sec_tick(ev[0]), .min_tick(ev[1]),
    .alarm_event(ev[2]), .corr_event(ev[3]), .tick_4096hz(tk[0]),
    .tick_64hz(tk[1]), .tick_1hz(tk[2]), .tick_60s(tk[3]),
    .int_pin_out(pin_out), .int_pin_oe_n(pin_oe_n));

  rtcirq_host_model host (.int_pin_out(pin_out), .int_pin_oe_n(pin_oe_n),
    .irq_n(irq_n));

  // ---------------------------------------------------------------
  // bus and strobe tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    req = '{1'b1, a, v};
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    req.addr = a;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask : rd

  task automatic pulse_ev(input logic [3:0] m);
    @(negedge sys_clk);
    ev = m;
    @(negedge sys_clk);
    ev = 4'h0;
  endtask : pulse_ev

  task automatic pulse_tk(input int s);
    @(negedge sys_clk);
    tk = 4'h1 << s;
    @(negedge sys_clk);
    tk = 4'h0;
  endtask : pulse_tk

  // counts cycles the pin stays low, bounded
  task automatic width(output int n);
    n = 0;
    while (irq_n === 1'b0 && n < 40) begin
      n++;
      @(negedge sys_clk);
    end
  endtask : width

  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rows[0] = '{8'h40, 4'h1, 8'h60, 1'b0};
    rows[1] = '{8'h80, 4'h2, 8'ha0, 1'b0};
    rows[2] = '{8'h00, 4'h1, 8'h00, 1'b1};
    rows[3] = '{8'h02, 4'h4, 8'h0a, 1'b0};
    rows[4] = '{8'h00, 4'h4, 8'h08, 1'b1};
    rows[5] = '{8'h00, 4'h8, 8'h00, 1'b0};
    rows[6] = '{8'h50, 4'h1, 8'h70, 1'b0};
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    rd(8'h01, d);
    `CHK("flag reg reset", 8'h00, d)
    rd(8'h0e, d);
    `CHK("timer ctrl reset", rtcirq_pkg::TIMER_CTRL_RST, d)
    rd(8'h05, d);
    `CHK("unmapped read", 8'h00, d)
    `CHK("pin after reset", 1'b1, irq_n)
    // table: config, event, resulting flags and pin level
    foreach (rows[i]) begin
      wr(8'h01, rows[i].cfg);
      repeat (20) @(negedge sys_clk);
      pulse_ev(rows[i].ev);
      `CHK("row pin", rows[i].pin, irq_n)
      rd(8'h01, d);
      `CHK("row flags", rows[i].flags, d)
    end
    // all three flags, then clears by write-and keeping config bits
    wr(8'h01, 8'h43);
    wr(8'h0e, 8'h08);
    wr(8'h0f, 8'h01);
    pulse_tk(0);
    wr(8'h0e, 8'h00);
    pulse_ev(4'h5);
    rd(8'h01, d);
    `CHK("all flags", 8'h6f, d)
    wr(8'h01, 8'h6f);
    rd(8'h01, d);
    `CHK("rewrite ones", 8'h6f, d)
    wr(8'h01, 8'h6b);
    rd(8'h01, d);
    `CHK("clear countdown", 8'h6b, d)
    wr(8'h01, 8'h4b);
    rd(8'h01, d);
    `CHK("clear ms flag", 8'h4b, d)
    `CHK("alarm holds pin", 1'b0, irq_n)
    wr(8'h01, 8'h43);
    `CHK("alarm clear pin", 1'b1, irq_n)
    // set event against a clearing write in one cycle
    @(negedge sys_clk);
    req = '{1'b1, 8'h01, 8'h02};
    ev = 4'h4;
    @(negedge sys_clk);
    req.wr = 1'b0;
    ev = 4'h0;
    rd(8'h01, d);
    `CHK("set wins", 8'h0a, d)
    // minute/second pulse width and early end
    wr(8'h01, 8'h50);
    pulse_ev(4'h1);
    width(w);
    `CHK("ms pulse width", P_MS, w)
    pulse_ev(4'h1);
    repeat (3) @(negedge sys_clk);
    wr(8'h01, 8'h50);
    `CHK("ms pulse cut", 1'b1, irq_n)
    // correction pulse width and shorten
    pulse_ev(4'h8);
    width(w);
    `CHK("corr width", P_CORR, w)
    pulse_ev(4'h8);
    wr(8'h00, 8'h02);
    `CHK("corr cut", 1'b1, irq_n)
    // countdown pulse widths over every source and n of 1 and 2
    for (int s = 0; s < 4; s++) begin
      for (int n = 1; n < 3; n++) begin
        wr(8'h01, 8'h11);
        wr(8'h0e, 8'h08 | 8'(s));
        wr(8'h0f, 8'(n));
        repeat (n) pulse_tk(s);
        width(w);
        w_exp = (s == 0) ? ((n == 1) ? P_F1 : P_F) :
                ((s == 1 && n == 1) ? P_S1 : P_S);
        `CHK("cd width", w_exp, w)
        rd(8'h01, d);
        `CHK("cd flag", 8'h15, d)
        rd(8'h0f, d);
        `CHK("cd reload", 8'(n), d)
      end
    end
    // value zero stops the countdown
    wr(8'h01, 8'h11);
    wr(8'h0f, 8'h00);
    repeat (3) pulse_tk(3);
    `CHK("stopped pin", 1'b1, irq_n)
    rd(8'h01, d);
    `CHK("stopped flag", 8'h11, d)
    // level mode countdown released by clearing its enable
    wr(8'h01, 8'h01);
    wr(8'h0f, 8'h01);
    pulse_tk(3);
    `CHK("cd level", 1'b0, irq_n)
    wr(8'h01, 8'h04);
    `CHK("cd enable off", 1'b1, irq_n)
    // clock enable low freezes the flags against an event
    ce = 1'b0;
    pulse_ev(4'h4);
    ce = 1'b1;
    rd(8'h01, d);
    `CHK("frozen flags", 8'h04, d)
    // level mode minute/second released by clearing both tick enables
    wr(8'h01, 8'h40);
    pulse_ev(4'h1);
    `CHK("ms level", 1'b0, irq_n)
    wr(8'h01, 8'h20);
    `CHK("ms enables off", 1'b1, irq_n)
    rd(8'h01, d);
    `CHK("ms flag kept", 8'h20, d)
    // reset in mid-run clears flags and releases the pin
    @(negedge sys_clk);
    nrst = 1'b0;
    @(negedge sys_clk);
    nrst = 1'b1;
    rd(8'h01, d);
    `CHK("flags after mid reset", 8'h00, d)
    `CHK("pin after mid reset", 1'b1, irq_n)
    tally_and_finish();
  end

endmodule : rtcirq_top_tb
